// File: hw/mqps_pkg.sv
// constants, types and helpers shared by both ends of the multi-queue port-select link
// assumes one clock for both ports and a synchronous active-low reset
package mqps_pkg;
   // -------------------------------------------------------------------------
   // sizes and fields
   // -------------------------------------------------------------------------
   localparam int unsigned MQPS_DW = 36;
   localparam int unsigned MQPS_QN = 4;
   localparam int unsigned MQPS_QW = 2;
   localparam int unsigned MQPS_IDW = 3;
   localparam int unsigned MQPS_DEPTH = 16;
   localparam int unsigned MQPS_LW = 5;
   localparam int unsigned MQPS_CW = 5;
   localparam int unsigned MQPS_SOP_BIT = 34;
   localparam int unsigned MQPS_EOP_BIT = 35;
   localparam int unsigned MQPS_WDEV_LSB = 2;
   localparam int unsigned MQPS_RDEV_LSB = 3;
   localparam int unsigned MQPS_CHG_CYCLES = 2;
   // -------------------------------------------------------------------------
   // thresholds and reset values
   // -------------------------------------------------------------------------
   // the full flag itself refuses writes, so two of the sixteen slots stay spare
   localparam logic [MQPS_LW-1:0] MQPS_FULL_LEVEL = 5'h0E;
   localparam logic [MQPS_LW-1:0] MQPS_AF_LEVEL = 5'h0C;
   localparam logic [MQPS_LW-1:0] MQPS_AE_LEVEL = 5'h02;
   localparam logic [MQPS_QW-1:0] MQPS_RST_QUEUE = 2'h0;
   localparam logic [MQPS_CW-1:0] MQPS_RST_COUNT = 5'h00;
   // -------------------------------------------------------------------------
   // types and helpers
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      MQPS_RUN = 2'b00,
      MQPS_REQ = 2'b01,
      MQPS_FILL = 2'b11
   } mqps_state_e;

   function automatic logic mqps_dev_match(input logic [MQPS_IDW-1:0] field, input logic [MQPS_IDW-1:0] id);
      mqps_dev_match = (field == id);
   endfunction : mqps_dev_match
endpackage : mqps_pkg

// File: hw/mqps_if.sv
// pin bundle between the queue device and its write/read controller
// assumes the bench supplies clock and reset to both ends separately
`timescale 1ns/1ps
interface mqps_if;
   import mqps_pkg::*;
   logic packet_mode_select;
   logic [MQPS_DW-1:0] write_data;
   logic write_enable_n;
   logic [4:0] write_address_bus;
   logic write_address_strobe;
   logic write_flag_strobe;
   logic full_flag_n;
   logic [MQPS_QN-1:0] almost_full_flag_bus;
   logic almost_full_flag_bus_oe;
   logic [MQPS_DW-1:0] read_data;
   logic read_data_oe;
   logic read_enable_n;
   logic output_enable_n;
   logic [5:0] read_address_bus;
   logic read_address_strobe;
   logic read_flag_strobe;
   logic output_valid_n;
   logic packet_ready_n;
   logic [MQPS_QN-1:0] almost_empty_flag;
   logic almost_empty_flag_oe;

   modport dev (
      input packet_mode_select, write_data, write_enable_n, write_address_bus, write_address_strobe,
      input write_flag_strobe, read_enable_n, output_enable_n, read_address_bus, read_address_strobe,
      input read_flag_strobe,
      output full_flag_n, almost_full_flag_bus, almost_full_flag_bus_oe, read_data, read_data_oe,
      output output_valid_n, packet_ready_n, almost_empty_flag, almost_empty_flag_oe
   );
   modport host (
      output packet_mode_select, write_data, write_enable_n, write_address_bus, write_address_strobe,
      output write_flag_strobe, read_enable_n, output_enable_n, read_address_bus, read_address_strobe,
      output read_flag_strobe,
      input full_flag_n, almost_full_flag_bus, almost_full_flag_bus_oe, read_data, read_data_oe,
      input output_valid_n, packet_ready_n, almost_empty_flag, almost_empty_flag_oe
   );
endinterface : mqps_if

// File: hw/mqps_device.sv
// four-queue device end: queue fifo and the port-select / flag logic around it
// assumes write and read ports share one clock and the controller keeps its own duties
`timescale 1ns/1ps
module mqps_fifo
   import mqps_pkg::*;
#(
   parameter int unsigned WIDTH = 36,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [AW:0] count_ff;
   logic push;
   logic pop;

   // depth must be a power of two so the pointers wrap on their own
   assign in_ready = (count_ff != DEPTH[AW:0]);
   assign out_valid = (count_ff != '0);
   assign out_data = mem[rd_ptr_ff];
   assign level = count_ff;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop && !push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule : mqps_fifo

module mqps_device
   import mqps_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // link to the controller
   mqps_if.dev link,
   // strap
   input wire logic [MQPS_IDW-1:0] device_id_pins
);
   // -------------------------------------------------------------------------
   // mode capture
   // -------------------------------------------------------------------------
   logic pkt_ff;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         pkt_ff <= link.packet_mode_select;
      end
   end

   // -------------------------------------------------------------------------
   // queue storage
   // -------------------------------------------------------------------------
   logic [MQPS_QN-1:0] f_in_valid;
   logic [MQPS_QN-1:0] f_in_ready;
   logic [MQPS_QN-1:0] f_out_valid;
   logic [MQPS_QN-1:0] f_out_ready;
   logic [MQPS_DW-1:0] f_out_data [MQPS_QN];
   logic [MQPS_LW-1:0] f_level [MQPS_QN];
   logic [MQPS_CW-1:0] pcnt_ff [MQPS_QN];

   for (genvar q = 0; q < MQPS_QN; q++) begin : g_queue
      mqps_fifo #(.WIDTH(MQPS_DW), .DEPTH(MQPS_DEPTH)) u_fifo (
         .clock(clock),
         .rstn(rstn),
         .in_valid(f_in_valid[q]),
         .in_ready(f_in_ready[q]),
         .in_data(link.write_data),
         .out_valid(f_out_valid[q]),
         .out_ready(f_out_ready[q]),
         .out_data(f_out_data[q]),
         .level(f_level[q])
      );

      // complete packets held: up on a stored end word, down when one leaves
      always_ff @(posedge clock) begin
         if (!rstn) begin
            pcnt_ff[q] <= MQPS_RST_COUNT;
         end else if (pkt_ff) begin
            pcnt_ff[q] <= pcnt_ff[q]
               + MQPS_CW'(f_in_valid[q] && f_in_ready[q] && link.write_data[MQPS_EOP_BIT])
               - MQPS_CW'(f_out_ready[q] && f_out_data[q][MQPS_EOP_BIT]);
         end
      end
   end

   // -------------------------------------------------------------------------
   // write port select
   // -------------------------------------------------------------------------
   logic [MQPS_QW-1:0] wq_act_ff;
   logic [MQPS_QW-1:0] wq_pend_ff;
   logic wsel_ff;
   logic wsel_pend_ff;
   logic wchg_ff;
   logic wflag_sel_ff;
   logic whit;
   logic full_flag_n_ff;
   logic [MQPS_LW-1:0] wlevel_nxt;
   logic [MQPS_QW-1:0] wq_flag;

   assign whit = mqps_dev_match(link.write_address_bus[4:MQPS_WDEV_LSB], device_id_pins);
   assign wq_flag = wchg_ff ? wq_pend_ff : wq_act_ff;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wq_act_ff <= MQPS_RST_QUEUE;
         wq_pend_ff <= MQPS_RST_QUEUE;
         wsel_ff <= 1'b1;
         wsel_pend_ff <= 1'b1;
         wchg_ff <= 1'b0;
      end else begin
         wchg_ff <= link.write_address_strobe && !link.write_flag_strobe;
         if (link.write_address_strobe && !link.write_flag_strobe) begin
            wq_pend_ff <= link.write_address_bus[MQPS_QW-1:0];
            wsel_pend_ff <= whit;
         end
         // old queue keeps taking writes until this edge
         if (wchg_ff) begin
            wq_act_ff <= wq_pend_ff;
            wsel_ff <= wsel_pend_ff;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wflag_sel_ff <= 1'b0;
      end else if (!link.write_address_strobe && link.write_flag_strobe) begin
         wflag_sel_ff <= whit;
      end
   end

   always_comb begin
      for (int q = 0; q < MQPS_QN; q++) begin
         f_in_valid[q] = !link.write_enable_n && wsel_ff && full_flag_n_ff
            && (wq_act_ff == q[MQPS_QW-1:0]);
      end
   end

   // -------------------------------------------------------------------------
   // write flags
   // -------------------------------------------------------------------------
   logic [MQPS_QN-1:0] af_bus_ff;
   logic af_oe_ff;

   // level after this edge, so a word the writer was just allowed is never refused
   assign wlevel_nxt = f_level[wq_flag] + MQPS_LW'(f_in_valid[wq_flag] && f_in_ready[wq_flag])
      - MQPS_LW'(f_out_ready[wq_flag]);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         full_flag_n_ff <= 1'b1;
         af_bus_ff <= '1;
         af_oe_ff <= 1'b0;
      end else begin
         full_flag_n_ff <= !(wlevel_nxt >= MQPS_FULL_LEVEL);
         for (int q = 0; q < MQPS_QN; q++) begin
            af_bus_ff[q] <= !(f_level[q] >= MQPS_AF_LEVEL);
         end
         af_oe_ff <= wflag_sel_ff;
      end
   end

   assign link.full_flag_n = full_flag_n_ff;
   assign link.almost_full_flag_bus = af_bus_ff;
   assign link.almost_full_flag_bus_oe = af_oe_ff;

   // -------------------------------------------------------------------------
   // read port select
   // -------------------------------------------------------------------------
   logic [MQPS_QW-1:0] rq_act_ff;
   logic [MQPS_QW-1:0] rq_pend_ff;
   logic rsel_ff;
   logic rsel_pend_ff;
   logic rchg_ff;
   logic rflag_sel_ff;
   logic rhit;

   assign rhit = mqps_dev_match(link.read_address_bus[5:MQPS_RDEV_LSB], device_id_pins);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rq_act_ff <= MQPS_RST_QUEUE;
         rq_pend_ff <= MQPS_RST_QUEUE;
         rsel_ff <= 1'b1;
         rsel_pend_ff <= 1'b1;
         rchg_ff <= 1'b0;
      end else begin
         // read enable plays no part in taking the selection
         rchg_ff <= link.read_address_strobe && !link.read_flag_strobe;
         if (link.read_address_strobe && !link.read_flag_strobe) begin
            rq_pend_ff <= link.read_address_bus[MQPS_QW-1:0];
            rsel_pend_ff <= rhit;
         end
         if (rchg_ff) begin
            rq_act_ff <= rq_pend_ff;
            rsel_ff <= rsel_pend_ff;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rflag_sel_ff <= 1'b0;
      end else if (!link.read_address_strobe && link.read_flag_strobe) begin
         rflag_sel_ff <= rhit;
      end
   end

   // -------------------------------------------------------------------------
   // read pipeline
   // -------------------------------------------------------------------------
   logic [MQPS_DW-1:0] data_ff;
   logic output_valid_n_ff;
   logic packet_ready_n_ff;
   logic data_oe_ff;
   logic [MQPS_QN-1:0] ae_bus_ff;
   logic ae_oe_ff;
   logic [MQPS_QW-1:0] pop_q;
   logic pop_sel;
   logic take;
   logic pop;
   logic [MQPS_QN-1:0] can_pop;

   always_comb begin
      for (int q = 0; q < MQPS_QN; q++) begin
         can_pop[q] = f_out_valid[q] && (!pkt_ff || (pcnt_ff[q] != '0));
      end
      pop_q = rchg_ff ? rq_pend_ff : rq_act_ff;
      pop_sel = rchg_ff ? rsel_pend_ff : rsel_ff;
      // on the request edge the old queue is read when enabled, or when the output word is invalid whatever enable is
      take = !output_valid_n_ff && !link.read_enable_n && rsel_ff;
      // switch edge loads the new queue whatever enable is
      pop = pop_sel && can_pop[pop_q] && (rchg_ff || output_valid_n_ff || take);
      for (int q = 0; q < MQPS_QN; q++) begin
         f_out_ready[q] = pop && (pop_q == q[MQPS_QW-1:0]);
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         data_ff <= '0;
      end else if (pop) begin
         data_ff <= f_out_data[pop_q];
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         output_valid_n_ff <= 1'b1;
      end else if (pop) begin
         output_valid_n_ff <= 1'b0;
      end else if (rchg_ff || take) begin
         // stale word stays on the bus but is marked invalid
         output_valid_n_ff <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         packet_ready_n_ff <= 1'b1;
         data_oe_ff <= 1'b0;
         ae_bus_ff <= '1;
         ae_oe_ff <= 1'b0;
      end else begin
         packet_ready_n_ff <= !(pkt_ff && (pcnt_ff[pop_q] != '0));
         data_oe_ff <= !link.output_enable_n;
         for (int q = 0; q < MQPS_QN; q++) begin
            ae_bus_ff[q] <= pkt_ff ? (pcnt_ff[q] == '0) : (f_level[q] <= MQPS_AE_LEVEL);
         end
         ae_oe_ff <= rflag_sel_ff;
      end
   end

   assign link.read_data = data_ff;
   assign link.read_data_oe = data_oe_ff;
   assign link.output_valid_n = output_valid_n_ff;
   assign link.packet_ready_n = packet_ready_n_ff;
   assign link.almost_empty_flag = ae_bus_ff;
   assign link.almost_empty_flag_oe = ae_oe_ff;
endmodule : mqps_device

// File: hw/mqps_host.sv
// controller end: turns user write/read requests into queue selects and port cycles
// assumes the device end shares the clock and that the user holds requests steady
`timescale 1ns/1ps
module mqps_host
   import mqps_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // link to the device
   mqps_if.host link,
   // setup
   input wire logic [MQPS_IDW-1:0] target_id,
   input wire logic packet_mode,
   // user write side
   input wire logic wr_valid,
   input wire logic [MQPS_QW-1:0] wr_queue,
   input wire logic [33:0] wr_data,
   input wire logic wr_sop,
   input wire logic wr_eop,
   output logic wr_ready,
   // user read side
   input wire logic [MQPS_QW-1:0] rd_queue,
   input wire logic rd_ready,
   output logic rd_valid,
   output logic [MQPS_DW-1:0] rd_data
);
   // -------------------------------------------------------------------------
   // write controller
   // -------------------------------------------------------------------------
   mqps_state_e wst_ff;
   logic [MQPS_QW-1:0] wq_cur_ff;
   logic wpkt_ff;
   logic wr_ready_ff;
   logic [MQPS_DW-1:0] wdata_ff;
   logic wen_n_ff;
   logic [4:0] waddr_ff;
   logic wstb_ff;
   logic pkt_ff;
   logic wacc;
   logic wchg;

   // one word per two clocks keeps the registered handshake simple
   assign wacc = (wst_ff == MQPS_RUN) && wr_valid && !wr_ready_ff && (wr_queue == wq_cur_ff) && link.full_flag_n;
   assign wchg = (wst_ff == MQPS_RUN) && wr_valid && !wr_ready_ff && (wr_queue != wq_cur_ff) && !wpkt_ff;

   // mode is passed on during reset too, since the device only captures it while rstn is low
   always_ff @(posedge clock) begin
      pkt_ff <= packet_mode;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wst_ff <= MQPS_RUN;
         wq_cur_ff <= MQPS_RST_QUEUE;
         wstb_ff <= 1'b0;
         waddr_ff <= '0;
      end else begin
         wstb_ff <= wchg;
         unique case (wst_ff)
            MQPS_RUN: begin
               if (wchg) begin
                  wst_ff <= MQPS_REQ;
                  wq_cur_ff <= wr_queue;
                  waddr_ff <= {target_id, wr_queue};
               end
            end
            MQPS_REQ: wst_ff <= MQPS_FILL;
            MQPS_FILL: wst_ff <= MQPS_RUN;
            default: wst_ff <= MQPS_RUN;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wen_n_ff <= 1'b1;
         wdata_ff <= '0;
         wr_ready_ff <= 1'b0;
         wpkt_ff <= 1'b0;
      end else begin
         wr_ready_ff <= wacc;
         if (wacc) begin
            wen_n_ff <= 1'b0;
            wdata_ff <= {wr_eop, wr_sop, wr_data};
            if (wr_eop) begin
               wpkt_ff <= 1'b0;
            end else if (wr_sop) begin
               wpkt_ff <= 1'b1;
            end
         end else if (wst_ff == MQPS_REQ && pkt_ff) begin
            // filler word closes the old queue, carrying no marker
            wen_n_ff <= 1'b0;
            wdata_ff <= '0;
         end else begin
            wen_n_ff <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // read controller
   // -------------------------------------------------------------------------
   mqps_state_e rst_ff;
   logic [MQPS_QW-1:0] rq_cur_ff;
   logic rpkt_ff;
   logic ren_n_ff;
   logic [5:0] raddr_ff;
   logic rstb_ff;
   logic rd_valid_ff;
   logic [MQPS_DW-1:0] rd_data_ff;
   logic rchg;
   logic rtake;
   logic deliver;

   assign rchg = (rst_ff == MQPS_RUN) && (rd_queue != rq_cur_ff) && !rpkt_ff;
   assign rtake = !ren_n_ff && !link.output_valid_n;
   // in packet mode a marker-free word outside a packet is filler and is dropped
   assign deliver = rtake && (!pkt_ff || rpkt_ff || link.read_data[MQPS_SOP_BIT]);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rst_ff <= MQPS_RUN;
         rq_cur_ff <= MQPS_RST_QUEUE;
         rstb_ff <= 1'b0;
         raddr_ff <= '0;
         ren_n_ff <= 1'b1;
      end else begin
         rstb_ff <= rchg;
         ren_n_ff <= !((rst_ff == MQPS_RUN) && !rchg && rd_ready);
         unique case (rst_ff)
            MQPS_RUN: begin
               if (rchg) begin
                  rst_ff <= MQPS_REQ;
                  rq_cur_ff <= rd_queue;
                  raddr_ff <= {target_id, 1'b0, rd_queue};
               end
            end
            MQPS_REQ: rst_ff <= MQPS_FILL;
            MQPS_FILL: rst_ff <= MQPS_RUN;
            default: rst_ff <= MQPS_RUN;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rd_valid_ff <= 1'b0;
         rd_data_ff <= '0;
         rpkt_ff <= 1'b0;
      end else begin
         rd_valid_ff <= deliver;
         if (deliver) begin
            rd_data_ff <= link.read_data;
            if (link.read_data[MQPS_EOP_BIT]) begin
               rpkt_ff <= 1'b0;
            end else if (link.read_data[MQPS_SOP_BIT]) begin
               rpkt_ff <= 1'b1;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // pin drive
   // -------------------------------------------------------------------------
   assign link.packet_mode_select = pkt_ff;
   assign link.write_data = wdata_ff;
   assign link.write_enable_n = wen_n_ff;
   assign link.write_address_bus = waddr_ff;
   assign link.write_address_strobe = wstb_ff;
   assign link.write_flag_strobe = 1'b0;
   assign link.read_enable_n = ren_n_ff;
   assign link.output_enable_n = 1'b0;
   assign link.read_address_bus = raddr_ff;
   assign link.read_address_strobe = rstb_ff;
   assign link.read_flag_strobe = 1'b0;
   assign wr_ready = wr_ready_ff;
   assign rd_valid = rd_valid_ff;
   assign rd_data = rd_data_ff;
endmodule : mqps_host

// File: bench/mqps_link_asserts.sv
// checker for the link between the host and device ends
// assumes one clock and a synchronous active-low reset shared by both ends
`timescale 1ns/1ps
module mqps_link_asserts
   import mqps_pkg::*;
#(
   parameter logic [MQPS_IDW-1:0] DEV_ID = 3'h5
) (
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // write port
   input wire logic packet_mode_select,
   input wire logic write_enable_n,
   input wire logic [MQPS_DW-1:0] write_data,
   input wire logic [4:0] write_address_bus,
   input wire logic write_address_strobe,
   // read port
   input wire logic [MQPS_DW-1:0] read_data,
   input wire logic read_data_oe,
   input wire logic output_enable_n,
   input wire logic [5:0] read_address_bus,
   input wire logic read_address_strobe,
   input wire logic read_enable_n,
   input wire logic output_valid_n,
   input wire logic packet_ready_n
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // ------
   // sequences
   // ------
   // data-change checks hold in standard mode only: two fillers may carry equal data
   sequence rd_chg_s;
      !packet_mode_select && read_address_strobe;
   endsequence
   sequence pop_s;
      !packet_mode_select && !output_valid_n && !read_enable_n && !read_address_strobe;
   endsequence
   // ------
   // assertions
   // ------
   wsel_dev_a:
      assert property (write_address_strobe |-> write_address_bus[4:2] == DEV_ID) else $error("bad write device");
   rsel_dev_a:
      assert property (read_address_strobe |-> read_address_bus[5:3] == DEV_ID) else $error("bad read device");
   oe_gate_a:
      assert property ($past(rstn) && !$past(output_enable_n) |-> read_data_oe) else $error("pins not driven");
   pkt_flag_a:
      assert property (!packet_mode_select |-> packet_ready_n) else $error("ready flag in standard mode");
   filler_clean_a:
      assert property (packet_mode_select && write_address_strobe |=> !write_enable_n && write_data[35:34] == 2'b00)
         else $error("filler missing or marked");
   stale_keep_a:
      assert property ($rose(output_valid_n) |-> $stable(read_data)) else $error("stale word lost");
   rd_change_a:
      assert property (rd_chg_s |-> ##2 (output_valid_n || $changed(read_data))) else $error("no load on change");
   flow_load_a:
      assert property (pop_s |=> output_valid_n || $changed(read_data)) else $error("no load after read");
endmodule : mqps_link_asserts

// File: bench/multi_queue_port_select_tb_top.sv
// bench: host and device ends joined by the link, checked against a queue model
// assumes one 25 MHz clock; rstn is held low for 20 cycles before each phase
`timescale 1ns/1ps
module multi_queue_port_select_tb_top;
   import mqps_pkg::*;
   localparam logic [MQPS_IDW-1:0] DEV_ID = 3'h5;
   // ------
   // stimulus and model
   // ------
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic packet_mode = 1'b0;
   logic wr_valid = 1'b0;
   logic [MQPS_QW-1:0] wr_queue = 2'h0;
   logic [33:0] wr_data = 34'h0;
   logic wr_sop = 1'b0;
   logic wr_eop = 1'b0;
   logic wr_ready;
   logic [MQPS_QW-1:0] rd_queue = 2'h0;
   logic rd_ready = 1'b0;
   logic rd_valid;
   logic [MQPS_DW-1:0] rd_data;
   logic [MQPS_DW-1:0] mq [MQPS_QN][$];
   logic [31:0] seed = 32'h476AD02F;
   logic [1:0] q;
   logic ok;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   int n;
   mqps_if l ();
   mqps_device u_mqps_device (.clock, .rstn, .link(l), .device_id_pins(DEV_ID));
   mqps_host u_mqps_host (.clock, .rstn, .link(l), .target_id(DEV_ID), .packet_mode, .wr_valid, .wr_queue,
      .wr_data, .wr_sop, .wr_eop, .wr_ready, .rd_queue, .rd_ready, .rd_valid, .rd_data);
   mqps_link_asserts #(.DEV_ID(DEV_ID)) u_mqps_link_asserts (.clock, .rstn,
      .packet_mode_select(l.packet_mode_select), .write_enable_n(l.write_enable_n), .write_data(l.write_data),
      .write_address_bus(l.write_address_bus), .write_address_strobe(l.write_address_strobe),
      .read_data(l.read_data), .read_data_oe(l.read_data_oe), .output_enable_n(l.output_enable_n),
      .read_address_bus(l.read_address_bus), .read_address_strobe(l.read_address_strobe),
      .read_enable_n(l.read_enable_n), .output_valid_n(l.output_valid_n), .packet_ready_n(l.packet_ready_n));
   always #20 clock = ~clock;
   // the whole run needs under a thousand cycles; the ceiling only cuts a hang
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         n_fail = n_fail + 1;
         tally_and_finish();
      end
   end
   // ------
   // tasks
   // ------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   endfunction : xs
   task automatic chk(input logic [MQPS_DW-1:0] seen, input logic [MQPS_DW-1:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic boot(input logic pm);
      @(negedge clock);
      rstn = 1'b0;
      packet_mode = pm;
      repeat (20) @(negedge clock);
      rstn = 1'b1;
   endtask : boot
   // a refused word is dropped after the wait, so the model keeps only taken words
   task automatic put(input logic [1:0] wq, input logic s, input logic e);
      seed = xs(seed);
      @(negedge clock);
      wr_valid = 1'b1;
      wr_queue = wq;
      wr_data = {seed, seed[1:0]};
      wr_sop = s;
      wr_eop = e;
      ok = 1'b0;
      repeat (60) begin
         @(posedge clock);
         #1;
         ok = (wr_ready === 1'b1);
         if (ok) break;
      end
      @(negedge clock);
      wr_valid = 1'b0;
      if (ok) mq[wq].push_back({e, s, wr_data});
   endtask : put
   task automatic get(input logic [1:0] rq, input int cnt);
      @(negedge clock);
      rd_queue = rq;
      n = 0;
      repeat (300) begin
         @(negedge clock);
         seed = xs(seed);
         rd_ready = seed[0] | seed[1];
         @(posedge clock);
         #1;
         if (rd_valid === 1'b1) begin
            chk(rd_data, mq[rq].pop_front());
            n = n + 1;
         end
         if (n == cnt) break;
      end
      @(negedge clock);
      rd_ready = 1'b0;
      chk(36'(n), 36'(cnt < 0 ? 0 : cnt));
   endtask : get
   // ------
   // main sequence
   // ------
   initial begin
      boot(1'b0);
      for (int i = 0; i < 28; i++) begin
         seed = xs(seed);
         q = seed[1:0];
         if (mq[q].size() > 9) q = q + 2'h1;
         put(q, 1'b0, 1'b0);
      end
      for (int i = 0; i < 4; i++) get(2'(i), mq[i].size());
      // fill one queue until it refuses, then drain it under random stalls
      for (int i = 0; i < 17; i++) begin
         put(2'h0, 1'b0, 1'b0);
         if (!ok) break;
      end
      chk(36'(mq[0].size()), 36'(MQPS_FULL_LEVEL));
      get(2'h0, mq[0].size());
      boot(1'b1);
      for (int i = 0; i < 4; i++) begin
         q = 2'(1 + i % 2);
         put(q, 1'b1, 1'b0);
         put(q, 1'b0, 1'b0);
         put(q, 1'b0, 1'b0);
         put(q, 1'b0, 1'b1);
      end
      put(2'h3, 1'b1, 1'b0);
      put(2'h3, 1'b0, 1'b0);
      get(2'h3, -1);
      // queue 3 holds half a packet; queues 1 and 2 two whole ones each
      chk(36'({l.packet_ready_n, l.almost_empty_flag}), 36'h19);
      get(2'h1, 8);
      get(2'h2, 8);
      tally_and_finish();
   end
endmodule : multi_queue_port_select_tb_top
